// *** verilog/ifs_top.sv ***
/*
 * Interrupt flag status registers, groups three and four, behind an
 * AXI4-Lite slave. Assumes request lines come from logic on clk and
 * stay high for at least one cycle per event.
 */
//
// Overview of operation
// R1: flag reads one after request, else zero
// R2: all flags clear on power-on reset
// R3: software may read, clear or force flags
// R4: unimplemented bits read zero, ignore writes
// R5: group3 bit15 pwm fault a, bit14 unused
// R6: group3 bit13 dma channel five done
// R7: group3 bit12 audio interface event
// R8: group3 bit11 audio interface error
// R9: group3 bit10 encoder event
// R10: group3 bit9 pwm error
// R11: group3 bit8 can b event, bit7 rx
// R12: group3 bit6 ext irq4, bit5 irq3
// R13: group3 bits 4,3,0 timers nine, eight, seven
// R14: group3 bit2 i2c b master, bit1 slave
// R15: group4 bits 7,6 can b, a tx
// R16: group4 bits 5,4 dma seven, six done
// R17: group4 bit3 unimplemented, reads zero
// R18: group4 bits 2,1 uart b, a error
// R19: group4 bit0 pwm fault b
// R20: set sticky until written zero; set wins
// R21: handler clears its flag before returning
//
`timescale 1ns/10ps
`include "ifs_consts.svh"

module ifs_top
	import ifs_pkg::*;
(
	input  wire logic                     clk,
	input  wire logic                     rst,
	// peripheral request lines
	input  wire logic                     pwm_fault_a_req,
	input  wire logic                     dma_ch5_done_req,
	input  wire logic                     audio_if_event_req,
	input  wire logic                     audio_if_error_req,
	input  wire logic                     encoder_event_req,
	input  wire logic                     pwm_error_req,
	input  wire logic                     can_b_event_req,
	input  wire logic                     can_b_rx_ready_req,
	input  wire logic                     ext_irq4_req,
	input  wire logic                     ext_irq3_req,
	input  wire logic                     timer_nine_req,
	input  wire logic                     timer_eight_req,
	input  wire logic                     timer_seven_req,
	input  wire logic                     i2c_b_master_req,
	input  wire logic                     i2c_b_slave_req,
	input  wire logic                     can_b_tx_request_req,
	input  wire logic                     can_a_tx_request_req,
	input  wire logic                     dma_ch7_done_req,
	input  wire logic                     dma_ch6_done_req,
	input  wire logic                     uart_b_error_req,
	input  wire logic                     uart_a_error_req,
	input  wire logic                     pwm_fault_b_req,
	// flag state toward the cpu interrupt logic
	output ifs_flags_t                    irq_flags_group3,
	output ifs_flags_t                    irq_flags_group4,
	// axi4-lite slave
	input  wire logic [`IFS_ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [`IFS_DATA_W-1:0]   s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [`IFS_ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [`IFS_DATA_W-1:0]        s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready
);

	ifs_flags_t                 set3;
	ifs_flags_t                 set4;
	ifs_flags_t                 wr_mask;
	logic                       aw_got_r;
	logic                       w_got_r;
	logic [`IFS_ADDR_W-1:0]     awaddr_r;
	logic [`IFS_DATA_W-1:0]     wdata_r;
	logic [3:0]                 wstrb_r;
	logic                       wr_fire;
	logic                       wr3;
	logic                       wr4;
	logic                       aw_hs;
	logic                       w_hs;
	logic                       ar_hs;
	ifs_sel_e                   wr_sel;
	ifs_sel_e                   rd_sel;

	// address decode shared by both channels
	function automatic ifs_sel_e ifs_decode(
		input logic [`IFS_ADDR_W-1:0] a
	);
		case (a)
			`IFS_OFS_GROUP3: ifs_decode = IFS_SEL_GROUP3;
			`IFS_OFS_GROUP4: ifs_decode = IFS_SEL_GROUP4;
			default:         ifs_decode = IFS_SEL_NONE;
		endcase
	endfunction : ifs_decode

	// request lines onto their flag positions
	always_comb begin
		set3 = `IFS_WORD_RST;
		set4 = `IFS_WORD_RST;
		set3[`IFS_POS_PWM_FAULT_A_FLAG]    = pwm_fault_a_req; // R5
		set3[`IFS_POS_DMA_CH5_DONE_FLAG]   = dma_ch5_done_req; // R6
		set3[`IFS_POS_AUDIO_IF_EVENT_FLAG] = audio_if_event_req; // R7
		set3[`IFS_POS_AUDIO_IF_ERROR_FLAG] = audio_if_error_req; // R8
		set3[`IFS_POS_ENCODER_EVENT_FLAG]  = encoder_event_req; // R9
		set3[`IFS_POS_PWM_ERROR_FLAG]      = pwm_error_req; // R10
		set3[`IFS_POS_CAN_B_EVENT_FLAG]    = can_b_event_req; // R11
		set3[`IFS_POS_CAN_B_RX_READY_FLAG] = can_b_rx_ready_req; // R11
		set3[`IFS_POS_EXT_IRQ4_FLAG]       = ext_irq4_req; // R12
		set3[`IFS_POS_EXT_IRQ3_FLAG]       = ext_irq3_req; // R12
		set3[`IFS_POS_TIMER_NINE_FLAG]     = timer_nine_req; // R13
		set3[`IFS_POS_TIMER_EIGHT_FLAG]    = timer_eight_req; // R13
		set3[`IFS_POS_TIMER_SEVEN_FLAG]    = timer_seven_req; // R13
		set3[`IFS_POS_I2C_B_MASTER_FLAG]   = i2c_b_master_req; // R14
		set3[`IFS_POS_I2C_B_SLAVE_FLAG]    = i2c_b_slave_req; // R14
		set4[`IFS_POS_CAN_B_TX_REQUEST_FLAG] = can_b_tx_request_req; // R15
		set4[`IFS_POS_CAN_A_TX_REQUEST_FLAG] = can_a_tx_request_req; // R15
		set4[`IFS_POS_DMA_CH7_DONE_FLAG]   = dma_ch7_done_req; // R16
		set4[`IFS_POS_DMA_CH6_DONE_FLAG]   = dma_ch6_done_req; // R16
		set4[`IFS_POS_UART_B_ERROR_FLAG]   = uart_b_error_req; // R18
		set4[`IFS_POS_UART_A_ERROR_FLAG]   = uart_a_error_req; // R18
		set4[`IFS_POS_PWM_FAULT_B_FLAG]    = pwm_fault_b_req; // R19
	end

	assign aw_hs   = s_axi_awvalid && s_axi_awready;
	assign w_hs    = s_axi_wvalid && s_axi_wready;
	assign ar_hs   = s_axi_arvalid && s_axi_arready;
	// write acts once both halves are held and no response is owed
	assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
	assign wr_sel  = ifs_decode(awaddr_r);
	assign rd_sel  = ifs_decode(s_axi_araddr);
	assign wr3     = wr_fire && (wr_sel == IFS_SEL_GROUP3);
	assign wr4     = wr_fire && (wr_sel == IFS_SEL_GROUP4);
	// only the two low byte lanes carry flag bits
	assign wr_mask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

	ifs_flag_reg #(
		.W         (`IFS_FLAG_W),
		.IMPL_MASK (`IFS_IMPL_GROUP3) // R4 R5
	) u_group3 (
		.clk     (clk),
		.rst     (rst),
		.set_req (set3),
		.wr_en   (wr3),
		.wr_mask (wr_mask),
		.wr_data (wdata_r[`IFS_FLAG_W-1:0]),
		.flags   (irq_flags_group3)
	);

	ifs_flag_reg #(
		.W         (`IFS_FLAG_W),
		.IMPL_MASK (`IFS_IMPL_GROUP4) // R4 R17
	) u_group4 (
		.clk     (clk),
		.rst     (rst),
		.set_req (set4),
		.wr_en   (wr4),
		.wr_mask (wr_mask),
		.wr_data (wdata_r[`IFS_FLAG_W-1:0]),
		.flags   (irq_flags_group4)
	);

	// write address channel
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			aw_got_r      <= 1'b0;
			awaddr_r      <= '0;
		end else if (aw_hs) begin
			s_axi_awready <= 1'b0;
			aw_got_r      <= 1'b1;
			awaddr_r      <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_got_r      <= 1'b0;
		end else if (!aw_got_r && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
		end
	end

	// write data channel
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_wready <= 1'b0;
			w_got_r      <= 1'b0;
			wdata_r      <= '0;
			wstrb_r      <= '0;
		end else if (w_hs) begin
			s_axi_wready <= 1'b0;
			w_got_r      <= 1'b1;
			wdata_r      <= s_axi_wdata;
			wstrb_r      <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_got_r      <= 1'b0;
		end else if (!w_got_r && !s_axi_bvalid) begin
			s_axi_wready <= 1'b1;
		end
	end

	// write response; unmapped writes are dropped and flagged
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `IFS_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wr_sel == IFS_SEL_NONE) ?
				`IFS_RESP_DECERR : `IFS_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read channel; data snapshot taken at the address handshake
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= `IFS_RESP_OKAY;
		end else if (ar_hs) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= `IFS_RESP_OKAY;
			case (rd_sel)
				IFS_SEL_GROUP3: begin
					s_axi_rdata <= {16'h0000, irq_flags_group3}; // R1
				end
				IFS_SEL_GROUP4: begin
					s_axi_rdata <= {16'h0000, irq_flags_group4}; // R1
				end
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= `IFS_RESP_DECERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	chk_reset_clear: assert property ( // R2
		@(posedge clk) disable iff (rst)
		$fell(rst) |-> irq_flags_group3 == `IFS_WORD_RST &&
			irq_flags_group4 == `IFS_WORD_RST)
		else $error("flags not clear after reset");

	chk_unused_bits: assert property ( // R4
		@(posedge clk) disable iff (rst)
		irq_flags_group3[14] == 1'b0 && irq_flags_group4[3] == 1'b0 &&
			irq_flags_group4[15:8] == 8'h00)
		else $error("unimplemented bit reads one");

	chk_set_wins: assert property ( // R20
		@(posedge clk) disable iff (rst)
		1'b1 |=> ((irq_flags_group3 & $past(set3)) == $past(set3)) &&
			((irq_flags_group4 & $past(set4)) == $past(set4)))
		else $error("request lost, flag not set");

	chk_fault_a_bit: assert property ( // R5
		@(posedge clk) disable iff (rst)
		pwm_fault_a_req |=> irq_flags_group3[15])
		else $error("fault a flag not at bit 15");

	chk_dma5_bit: assert property ( // R6
		@(posedge clk) disable iff (rst)
		dma_ch5_done_req |=> irq_flags_group3[13])
		else $error("dma5 flag not at bit 13");

	chk_timer7_bit: assert property ( // R13
		@(posedge clk) disable iff (rst)
		timer_seven_req |=> irq_flags_group3[0])
		else $error("timer seven flag not at bit 0");

	chk_fault_b_bit: assert property ( // R19
		@(posedge clk) disable iff (rst)
		pwm_fault_b_req |=> irq_flags_group4[0])
		else $error("fault b flag not at bit 0");

	chk_can_tx_bits: assert property ( // R15
		@(posedge clk) disable iff (rst)
		can_b_tx_request_req || can_a_tx_request_req |=>
			(irq_flags_group4[7:6] & $past({can_b_tx_request_req,
			can_a_tx_request_req})) == $past({can_b_tx_request_req,
			can_a_tx_request_req}))
		else $error("can tx flags misplaced");

	chk_ext_irq_bits: assert property ( // R12
		@(posedge clk) disable iff (rst)
		ext_irq4_req || ext_irq3_req |=>
			(irq_flags_group3[6:5] & $past({ext_irq4_req, ext_irq3_req}))
			== $past({ext_irq4_req, ext_irq3_req}))
		else $error("external irq flags misplaced");

	chk_dma67_bits: assert property ( // R16
		@(posedge clk) disable iff (rst)
		dma_ch7_done_req || dma_ch6_done_req |=>
			(irq_flags_group4[5:4] & $past({dma_ch7_done_req,
			dma_ch6_done_req})) == $past({dma_ch7_done_req,
			dma_ch6_done_req}))
		else $error("dma six or seven flag misplaced");

	chk_uart_err_bits: assert property ( // R18
		@(posedge clk) disable iff (rst)
		uart_b_error_req || uart_a_error_req |=>
			(irq_flags_group4[2:1] & $past({uart_b_error_req,
			uart_a_error_req})) == $past({uart_b_error_req,
			uart_a_error_req}))
		else $error("uart error flags misplaced");

	chk_write_clear: assert property ( // R3
		@(posedge clk) disable iff (rst)
		wr3 && set3 == `IFS_WORD_RST && wr_mask[7:0] == 8'hff &&
			wdata_r[7:0] == 8'h00
			|=> irq_flags_group3[7:0] == 8'h00)
		else $error("software clear of group3 not taken");

	// a second write must wait until the owed response is gone
	chk_aw_blocked: assert property (
		@(posedge clk) disable iff (rst)
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write channel open while response owed");

	chk_write_resp: assert property (
		@(posedge clk) disable iff (rst)
		aw_hs && w_hs |=> wr_fire ##1 s_axi_bvalid)
		else $error("write response not two cycles after handshake");

	chk_read_data: assert property ( // R1
		@(posedge clk) disable iff (rst)
		ar_hs && rd_sel == IFS_SEL_GROUP4 |=> s_axi_rvalid &&
			s_axi_rdata == {16'h0000, $past(irq_flags_group4)})
		else $error("group4 read data wrong");

	chk_unmapped_rd: assert property (
		@(posedge clk) disable iff (rst)
		ar_hs && rd_sel == IFS_SEL_NONE |=>
			s_axi_rresp == `IFS_RESP_DECERR && s_axi_rdata == '0)
		else $error("unmapped read not refused");

	chk_rvalid_hold: assert property (
		@(posedge clk) disable iff (rst)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
			$stable(s_axi_rdata))
		else $error("read data dropped before rready");

endmodule : ifs_top

// *** verilog/ifs_consts.svh ***
/*
 * Constants of the interrupt flag status block: register offsets,
 * bit positions of every flag, implemented masks, bus codes.
 * Assumes inclusion by bare name from the block's design files.
 */
`ifndef IFS_CONSTS_SVH
`define IFS_CONSTS_SVH

`define IFS_ADDR_W        8
`define IFS_DATA_W        32
`define IFS_FLAG_W        16
`define IFS_OFS_GROUP3    8'h00
`define IFS_OFS_GROUP4    8'h04
`define IFS_IMPL_GROUP3   16'hbfff
`define IFS_IMPL_GROUP4   16'h00f7
`define IFS_FLAG_RST      1'b0
`define IFS_WORD_RST      16'h0000
`define IFS_RESP_OKAY     2'b00
`define IFS_RESP_DECERR   2'b11

`define IFS_POS_PWM_FAULT_A_FLAG       15
`define IFS_POS_DMA_CH5_DONE_FLAG      13
`define IFS_POS_AUDIO_IF_EVENT_FLAG    12
`define IFS_POS_AUDIO_IF_ERROR_FLAG    11
`define IFS_POS_ENCODER_EVENT_FLAG     10
`define IFS_POS_PWM_ERROR_FLAG         9
`define IFS_POS_CAN_B_EVENT_FLAG       8
`define IFS_POS_CAN_B_RX_READY_FLAG    7
`define IFS_POS_EXT_IRQ4_FLAG          6
`define IFS_POS_EXT_IRQ3_FLAG          5
`define IFS_POS_TIMER_NINE_FLAG        4
`define IFS_POS_TIMER_EIGHT_FLAG       3
`define IFS_POS_I2C_B_MASTER_FLAG      2
`define IFS_POS_I2C_B_SLAVE_FLAG       1
`define IFS_POS_TIMER_SEVEN_FLAG       0

`define IFS_POS_CAN_B_TX_REQUEST_FLAG  7
`define IFS_POS_CAN_A_TX_REQUEST_FLAG  6
`define IFS_POS_DMA_CH7_DONE_FLAG      5
`define IFS_POS_DMA_CH6_DONE_FLAG      4
`define IFS_POS_UART_B_ERROR_FLAG      2
`define IFS_POS_UART_A_ERROR_FLAG      1
`define IFS_POS_PWM_FAULT_B_FLAG       0

`endif

// *** verilog/ifs_pkg.sv ***
/*
 * Types of the interrupt flag status block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ifs_pkg;

	typedef enum logic [1:0] {
		IFS_SEL_GROUP3 = 2'b00,
		IFS_SEL_GROUP4 = 2'b01,
		IFS_SEL_NONE   = 2'b10
	} ifs_sel_e;

	typedef logic [15:0] ifs_flags_t;

endpackage : ifs_pkg

// *** verilog/ifs_flag_reg.sv ***
/*
 * One 16-bit sticky interrupt flag register.
 * Assumes set requests and write strobes come from logic on clk.
 */
`timescale 1ns/10ps
`include "ifs_consts.svh"

module ifs_flag_reg #(
	parameter int                W         = `IFS_FLAG_W,
	parameter logic [W-1:0]      IMPL_MASK = {W{1'b1}}
) (
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire logic [W-1:0]    set_req,
	input  wire logic            wr_en,
	input  wire logic [W-1:0]    wr_mask,
	input  wire logic [W-1:0]    wr_data,
	output logic      [W-1:0]    flags
);

	for (genvar i = 0; i < W; i++) begin : g_bit
		if (IMPL_MASK[i]) begin : g_impl
			// set beats a same-cycle write so no event is lost
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					flags[i] <= `IFS_FLAG_RST; // R2
				end else if (set_req[i]) begin
					flags[i] <= 1'b1; // R1 R20
				end else if (wr_en && wr_mask[i]) begin
					flags[i] <= wr_data[i]; // R3
				end
			end
		end else begin : g_unimpl
			assign flags[i] = `IFS_FLAG_RST; // R4
		end
	end

	chk_unimpl_zero: assert property ( // R4
		@(posedge clk) disable iff (rst)
		(flags & ~IMPL_MASK) == '0)
		else $error("unimplemented flag bit reads one");

	chk_flag_hold: assert property ( // R20
		@(posedge clk) disable iff (rst)
		!wr_en |=> (flags & $past(flags)) == $past(flags))
		else $error("flag dropped without a clearing write");

endmodule : ifs_flag_reg

// *** verification/ifs_src_model.sv ***
/*
 * Peripheral request sources facing the flag block: one request line
 * per implemented flag, driven from two flag-shaped fire vectors.
 * Assumes the bench changes the fire vectors just after a clock edge.
 */
`timescale 1ns/10ps
`include "ifs_consts.svh"

module ifs_src_model
	import ifs_pkg::*;
(
	input  wire ifs_flags_t f3,
	input  wire ifs_flags_t f4,
	output logic            pwm_fault_a_req,
	output logic            dma_ch5_done_req,
	output logic            audio_if_event_req,
	output logic            audio_if_error_req,
	output logic            encoder_event_req,
	output logic            pwm_error_req,
	output logic            can_b_event_req,
	output logic            can_b_rx_ready_req,
	output logic            ext_irq4_req,
	output logic            ext_irq3_req,
	output logic            timer_nine_req,
	output logic            timer_eight_req,
	output logic            timer_seven_req,
	output logic            i2c_b_master_req,
	output logic            i2c_b_slave_req,
	output logic            can_b_tx_request_req,
	output logic            can_a_tx_request_req,
	output logic            dma_ch7_done_req,
	output logic            dma_ch6_done_req,
	output logic            uart_b_error_req,
	output logic            uart_a_error_req,
	output logic            pwm_fault_b_req
);
	// unused positions have no source, so firing them must do nothing
	assign pwm_fault_a_req = f3[15];
	assign dma_ch5_done_req = f3[13];
	assign audio_if_event_req = f3[12];
	assign audio_if_error_req = f3[11];
	assign encoder_event_req = f3[10];
	assign pwm_error_req = f3[9];
	assign can_b_event_req = f3[8];
	assign can_b_rx_ready_req = f3[7];
	assign ext_irq4_req = f3[6];
	assign ext_irq3_req = f3[5];
	assign timer_nine_req = f3[4];
	assign timer_eight_req = f3[3];
	assign i2c_b_master_req = f3[2];
	assign i2c_b_slave_req = f3[1];
	assign timer_seven_req = f3[0];
	assign can_b_tx_request_req = f4[7];
	assign can_a_tx_request_req = f4[6];
	assign dma_ch7_done_req = f4[5];
	assign dma_ch6_done_req = f4[4];
	assign uart_b_error_req = f4[2];
	assign uart_a_error_req = f4[1];
	assign pwm_fault_b_req = f4[0];
endmodule : ifs_src_model

// *** verification/ifs_top_tb.sv ***
/*
 * Self-checking bench for ifs_top with an integer model of both flag
 * registers. Assumes design files and ifs_src_model compiled first.
 */
`timescale 1ns/10ps
`include "ifs_consts.svh"

module ifs_top_tb
	import ifs_pkg::*;
;
	localparam logic [7:0] A3 = `IFS_OFS_GROUP3;
	localparam logic [7:0] A4 = `IFS_OFS_GROUP4;
	logic clk, rst, p15, p13, p12, p11, p10, p9, p8, p7, p6, p5, p4, p3;
	logic p0, p2, p1, q7, q6, q5, q4, q2, q1, q0;
	ifs_flags_t f3, f4, irq_flags_group3, irq_flags_group4;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, seed;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	int          miscompares, n_tests, g3, g4;

	always #25 clk = ~clk;

	ifs_src_model ifs_src_model_inst (.f3(f3), .f4(f4),
		.pwm_fault_a_req(p15), .dma_ch5_done_req(p13),
		.audio_if_event_req(p12), .audio_if_error_req(p11),
		.encoder_event_req(p10), .pwm_error_req(p9), .can_b_event_req(p8),
		.can_b_rx_ready_req(p7), .ext_irq4_req(p6), .ext_irq3_req(p5),
		.timer_nine_req(p4), .timer_eight_req(p3), .timer_seven_req(p0),
		.i2c_b_master_req(p2), .i2c_b_slave_req(p1),
		.can_b_tx_request_req(q7), .can_a_tx_request_req(q6),
		.dma_ch7_done_req(q5), .dma_ch6_done_req(q4),
		.uart_b_error_req(q2), .uart_a_error_req(q1), .pwm_fault_b_req(q0));

	ifs_top ifs_top_inst (.clk(clk), .rst(rst),
		.pwm_fault_a_req(p15), .dma_ch5_done_req(p13),
		.audio_if_event_req(p12), .audio_if_error_req(p11),
		.encoder_event_req(p10), .pwm_error_req(p9), .can_b_event_req(p8),
		.can_b_rx_ready_req(p7), .ext_irq4_req(p6), .ext_irq3_req(p5),
		.timer_nine_req(p4), .timer_eight_req(p3), .timer_seven_req(p0),
		.i2c_b_master_req(p2), .i2c_b_slave_req(p1),
		.can_b_tx_request_req(q7), .can_a_tx_request_req(q6),
		.dma_ch7_done_req(q5), .dma_ch6_done_req(q4),
		.uart_b_error_req(q2), .uart_a_error_req(q1), .pwm_fault_b_req(q0),
		.irq_flags_group3(irq_flags_group3),
		.irq_flags_group4(irq_flags_group4),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish

	// look at the flag ports mid-cycle, where they have settled
	task see_flags();
		@(negedge clk);
		chk(irq_flags_group3, g3);
		chk(irq_flags_group4, g4);
		@(posedge clk);
	endtask : see_flags

	task pulse(input logic [15:0] s3, input logic [15:0] s4);
		f3 <= s3;
		f4 <= s4;
		@(posedge clk);
		f3 <= '0;
		f4 <= '0;
		g3 |= s3 & `IFS_IMPL_GROUP3;
		g4 |= s4 & `IFS_IMPL_GROUP4;
		see_flags();
	endtask : pulse

	// c3/c4 fire requests in the cycle the write lands, to collide
	task axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [15:0] c3, input logic [15:0] c4);
		logic aw, w, ad, wd, b;
		logic [1:0] br;
		logic [15:0] m;
		ad = 0;
		wd = 0;
		b = 0;
		br = (a == A3 || a == A4) ? `IFS_RESP_OKAY : `IFS_RESP_DECERR;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ad && wd)) begin
			@(negedge clk);
			aw = awvalid & awready;
			w = wvalid & wready;
			@(posedge clk);
			if (aw) begin
				awvalid <= 1'b0;
				ad = 1;
			end
			if (w) begin
				wvalid <= 1'b0;
				wd = 1;
			end
		end
		f3 <= c3;
		f4 <= c4;
		bready <= 1'b1;
		while (!b) begin
			@(negedge clk);
			b = bvalid;
			// bresp is only meaningful while bvalid stands
			if (b) begin
				chk(bresp, br);
			end
			@(posedge clk);
			f3 <= '0;
			f4 <= '0;
		end
		bready <= 1'b0;
		m = {{8{s[1]}}, {8{s[0]}}};
		if (a == A3) begin
			g3 = (g3 & ~m) | (d[15:0] & m & `IFS_IMPL_GROUP3);
		end
		if (a == A4) begin
			g4 = (g4 & ~m) | (d[15:0] & m & `IFS_IMPL_GROUP4);
		end
		g3 |= c3 & `IFS_IMPL_GROUP3;
		g4 |= c4 & `IFS_IMPL_GROUP4;
		see_flags();
	endtask : axi_wr

	task axi_rd(input logic [7:0] a);
		logic ar, r;
		logic [31:0] e;
		ar = 0;
		r = 0;
		araddr <= a;
		arvalid <= 1'b1;
		while (!ar) begin
			@(negedge clk);
			ar = arvalid & arready;
			@(posedge clk);
		end
		arvalid <= 1'b0;
		rready <= 1'b1;
		e = (a == A3) ? g3 : ((a == A4) ? g4 : 0);
		while (!r) begin
			@(negedge clk);
			r = rvalid;
			if (r) begin
				chk(rdata, e);
				chk(rresp, (a != A3 && a != A4) ?
					`IFS_RESP_DECERR : `IFS_RESP_OKAY);
			end
			@(posedge clk);
		end
		rready <= 1'b0;
	endtask : axi_rd

	initial begin
		repeat (6000) @(posedge clk);
		miscompares++;
		tally_and_finish();
	end

	initial begin
		clk = 0;
		rst = 1;
		seed = 32'd93;
		{f3, f4, awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{g3, g4, miscompares, n_tests} = '0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		see_flags();
		axi_rd(A3);
		axi_rd(A4);
		for (int i = 0; i < 16; i++) begin
			pulse(16'h1 << i, 16'h0);
			pulse(16'h0, 16'h1 << i);
		end
		repeat (5) @(posedge clk);
		see_flags();
		axi_rd(A3);
		axi_rd(A4);
		axi_wr(A3, 32'h0, 4'h1, 16'h0, 16'h0);
		axi_wr(A4, 32'hffffffff, 4'hf, 16'h0, 16'h0);
		axi_wr(A3, 32'h0, 4'hf, 16'h8001, 16'h0);
		axi_wr(A4, 32'h0, 4'hf, 16'h0, 16'h0081);
		for (int i = 0; i < 10; i++) begin
			axi_wr(8'(xs()) & 8'h04, xs(), 4'(xs()), 16'(xs() & xs()),
				16'(xs() & xs()));
			axi_rd(8'(xs()) & 8'h04);
		end
		axi_wr(8'h08, 32'hffffffff, 4'hf, 16'h0, 16'h0);
		axi_wr(8'h02, 32'hffffffff, 4'hf, 16'h0, 16'h0);
		axi_rd(8'h08);
		axi_wr(A3, 32'hffffffff, 4'hf, 16'h0, 16'h0);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		g3 = 0;
		g4 = 0;
		see_flags();
		axi_rd(A3);
		tally_and_finish();
	end
endmodule : ifs_top_tb
